/* File: gpio_pkg.sv */
// Function
// RULE1: Five identical independent port copies.
// RULE2: Output pin may toggle every two clocks.
// RULE3: Cleared digital enable isolates input path.
// RULE4: Peripheral needs select, enable and code.
// RULE5: Every pin is configured on its own.
// RULE6: Other pins reset tri-stated, all zero.
// RULE7: Serial and debug pins reset to functions.
// RULE8: Both reset sources restore pin defaults.
// RULE9: Pins reset as inputs except debug pins.
// RULE10: Top pin of port B reverts to reset.
// RULE11: Direction chooses input capture or drive.
// RULE12: Edge or level interrupt sensing, software selected.
// RULE13: Data access masked by address lines.
// RULE14: Port logic can trigger converter sampling.
// RULE15: Direction zero captures, one drives data.
// RULE16: Address bits nine to two mask data.
// RULE17: One interrupt per port, edges stay pending.
// RULE18: Alternate select hands pin to peripheral.
// RULE19: State held in flops, reset loads defaults.
// RULE20: Pin inputs pass a synchroniser first.
package gpio_pkg;
   localparam int N_PORTS = 5;
   localparam int N_PINS = 8;
   localparam int CODE_W = 4;
   typedef logic [N_PORTS-1:0][N_PINS-1:0] port_bits_t;
   typedef logic [N_PORTS-1:0][N_PINS*CODE_W-1:0] port_codes_t;
   localparam logic [2:0] PORT_LIMIT = 3'h5;
   localparam int PORT_LSB = 12;
   localparam int MASK_LSB = 2;
   localparam int CTRL_BIT = 10;
   localparam logic [2:0] SIZE_WORD = 3'h2;
   localparam logic [11:0] OFF_DIR = 12'h400;
   localparam logic [11:0] OFF_IS = 12'h404;
   localparam logic [11:0] OFF_IBE = 12'h408;
   localparam logic [11:0] OFF_IEV = 12'h40C;
   localparam logic [11:0] OFF_IM = 12'h410;
   localparam logic [11:0] OFF_RIS = 12'h414;
   localparam logic [11:0] OFF_MIS = 12'h418;
   localparam logic [11:0] OFF_ICR = 12'h41C;
   localparam logic [11:0] OFF_AFSEL = 12'h420;
   localparam logic [11:0] OFF_PUR = 12'h424;
   localparam logic [11:0] OFF_PDR = 12'h428;
   localparam logic [11:0] OFF_DEN = 12'h42C;
   localparam logic [11:0] OFF_PCTL = 12'h430;
   localparam int ADC_PORT = 1;
   localparam int ADC_PIN = 4;
   // Byte order per constant is port E down to port A.
   localparam port_bits_t AFSEL_RST = 40'h00000F803F;
   localparam port_bits_t DEN_RST = 40'h00000F803F;
   localparam port_bits_t PUR_RST = 40'h00000F0000;
   localparam port_bits_t PDR_RST = 40'h0000000000;
   localparam port_bits_t DIR_RST = 40'h0000000000;
   localparam port_codes_t PCTL_RST = {32'h00000000, 32'h00000000,
      32'h00003333, 32'h30000000, 32'h00111111};

   function automatic logic [2:0] port_of(input logic [14:0] a);
      return a[PORT_LSB+2:PORT_LSB];
   endfunction

   function automatic logic [7:0] mask_of(input logic [14:0] a);
      return a[MASK_LSB+7:MASK_LSB];
   endfunction

   function automatic logic is_data(input logic [14:0] a);
      return !a[CTRL_BIT] && !a[CTRL_BIT+1];
   endfunction
endpackage

/* File: pin_sync.sv */
`timescale 1ns/100ps
module pin_sync #(
   parameter int WIDTH = 1
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] din,
   output logic [WIDTH-1:0] dout
);
   logic [WIDTH-1:0] s1_reg, s2_reg, s3_reg, out_reg;
   logic [WIDTH-1:0] out_next;
   logic [WIDTH-1:0] agree;

   // Only the second and third stages are compared; the first is left
   // alone so it can settle out of metastability.
   always_comb begin
      agree = ~(s2_reg ^ s3_reg);
      out_next = (agree & s3_reg) | (~agree & out_reg); // RULE20
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_reg <= '0;
         s2_reg <= '0;
         s3_reg <= '0;
         out_reg <= '0;
      end else begin
         s1_reg <= din;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         out_reg <= out_next;
      end
   end

   assign dout = out_reg;
endmodule

/* File: irq_sense.sv */
`timescale 1ns/100ps
module irq_sense #(
   parameter int WIDTH = 8
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] level,
   input wire logic [WIDTH-1:0] sense_level,
   input wire logic [WIDTH-1:0] both_edges,
   input wire logic [WIDTH-1:0] high_rise,
   input wire logic [WIDTH-1:0] clear,
   output logic [WIDTH-1:0] raw
);
   logic [WIDTH-1:0] prev_reg, raw_reg;
   logic [WIDTH-1:0] prev_next, raw_next;
   logic [WIDTH-1:0] rise, fall, edge_hit, lvl_hit;

   always_comb begin
      prev_next = level;
      rise = level & ~prev_reg;
      fall = ~level & prev_reg;
      edge_hit = (both_edges & (rise | fall)) |
         (~both_edges & high_rise & rise) |
         (~both_edges & ~high_rise & fall); // RULE12
      lvl_hit = (high_rise & level) | (~high_rise & ~level);
      // A new edge in the clearing cycle keeps the flag set.
      raw_next = (sense_level & lvl_hit) |
         (~sense_level & (edge_hit | (raw_reg & ~clear))); // RULE17
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prev_reg <= '0;
         raw_reg <= '0;
      end else begin
         prev_reg <= prev_next;
         raw_reg <= raw_next;
      end
   end

   assign raw = raw_reg;
endmodule

/* File: gpio_ports.sv */
// Decided for this implementation: the register addresses and the AHB-Lite slave port.
`timescale 1ns/100ps
module gpio_ports #(
   parameter int NUM_PORTS = 5,
   parameter int PINS = 8
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [14:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire gpio_pkg::port_bits_t pin_in,
   output gpio_pkg::port_bits_t pin_out,
   output gpio_pkg::port_bits_t pin_oe,
   output gpio_pkg::port_bits_t pin_pull_up,
   output gpio_pkg::port_bits_t pin_pull_down,
   output gpio_pkg::port_bits_t pin_digital_en,
   input wire gpio_pkg::port_bits_t periph_out,
   input wire gpio_pkg::port_bits_t periph_oe,
   output gpio_pkg::port_bits_t periph_in,
   output gpio_pkg::port_codes_t pin_function_code,
   output logic [gpio_pkg::N_PORTS-1:0] port_irq,
   output logic adc_trigger
);
   import gpio_pkg::*;

   // The address map and reset tables are built for this exact shape.
   if (NUM_PORTS != N_PORTS || PINS != N_PINS) begin : g_shape_check
      $error("gpio_ports supports only five ports of eight pins");
   end

   // Per-port configuration, every bit its own flop.
   port_bits_t data_reg, data_next;
   port_bits_t dir_reg, dir_next;
   port_bits_t is_reg, is_next;
   port_bits_t ibe_reg, ibe_next;
   port_bits_t iev_reg, iev_next;
   port_bits_t im_reg, im_next;
   port_bits_t afsel_reg, afsel_next;
   port_bits_t pur_reg, pur_next;
   port_bits_t pdr_reg, pdr_next;
   port_bits_t den_reg, den_next;
   port_codes_t pctl_reg, pctl_next;

   // Bus slave state.
   logic wr_pend_reg, wr_pend_next;
   logic [14:0] wr_addr_reg, wr_addr_next;
   logic [31:0] hrdata_reg, hrdata_next;
   logic hready_reg, hready_next;
   logic hresp_reg, hresp_next;

   // Registered pin and peripheral side.
   port_bits_t pin_out_reg, pin_out_next;
   port_bits_t pin_oe_reg, pin_oe_next;
   port_bits_t periph_in_reg, periph_in_next;
   port_codes_t code_reg, code_next;
   logic [N_PORTS-1:0] irq_reg, irq_next;
   logic adc_reg, adc_next;

   // Helpers.
   port_bits_t pin_sync_val;
   port_bits_t din_gated;
   port_bits_t ris;
   port_bits_t icr_pulse;
   logic accept;
   logic [2:0] rp;
   logic [2:0] wp;
   logic [7:0] rmask;
   logic [7:0] wmask;
   logic [7:0] rbyte;

   // One synchroniser serves all forty pins. A pin that moves while it
   // is sampled is only taken once two stages agree on its level.
   pin_sync #(
      .WIDTH(N_PORTS*N_PINS)
   ) u_pin_sync (
      .clk(hclk),
      .rst_n(hresetn),
      .din(pin_in),
      .dout(pin_sync_val)
   );

   // An analog pin has its digital enable cleared; its input then
   // reads as zero and cannot capture, though low-level sensing still flags it.
   assign din_gated = pin_sync_val & den_reg; // RULE3

   for (genvar p = 0; p < N_PORTS; p++) begin : g_port
      irq_sense #(
         .WIDTH(N_PINS)
      ) u_irq_sense (
         .clk(hclk),
         .rst_n(hresetn),
         .level(din_gated[p]),
         .sense_level(is_reg[p]),
         .both_edges(ibe_reg[p]),
         .high_rise(iev_reg[p]),
         .clear(icr_pulse[p]),
         .raw(ris[p])
      ); // RULE1
   end

   // Bus front end and register update.
   always_comb begin
      data_next = data_reg;
      dir_next = dir_reg;
      is_next = is_reg;
      ibe_next = ibe_reg;
      iev_next = iev_reg;
      im_next = im_reg;
      afsel_next = afsel_reg;
      pur_next = pur_reg;
      pdr_next = pdr_reg;
      den_next = den_reg;
      pctl_next = pctl_reg;
      icr_pulse = '0;
      wr_addr_next = wr_addr_reg;
      hrdata_next = hrdata_reg;
      // Reads answer at once; only writes insert a wait state.
      hready_next = 1'b1;
      // Every transfer ends with an OKAY response.
      hresp_next = 1'b0;
      wr_pend_next = 1'b0;
      accept = hsel && hready && htrans[1];
      rp = port_of(haddr);
      wp = port_of(wr_addr_reg);
      rmask = mask_of(haddr);
      wmask = mask_of(wr_addr_reg);
      rbyte = 8'h00;

      // Input bits follow the pin; output bits keep the stored value.
      for (int p = 0; p < N_PORTS; p++) begin
         data_next[p] = (data_reg[p] & dir_reg[p]) |
            (din_gated[p] & ~dir_reg[p]); // RULE15
      end

      // Writes take one wait state so that the new value is in place
      // before any following read is sampled.
      // A write of less than a word takes its wait state but changes nothing.
      if (accept && hwrite) begin
         wr_pend_next = (hsize == SIZE_WORD);
         wr_addr_next = haddr;
         hready_next = 1'b0;
      end else if (accept && rp < PORT_LIMIT) begin
         if (is_data(haddr)) begin
            rbyte = data_reg[rp] & rmask; // RULE13
            hrdata_next = {24'h000000, rbyte};
         end else begin
            unique case (haddr[11:0])
               OFF_DIR: hrdata_next = {24'h000000, dir_reg[rp]};
               OFF_IS: hrdata_next = {24'h000000, is_reg[rp]};
               OFF_IBE: hrdata_next = {24'h000000, ibe_reg[rp]};
               OFF_IEV: hrdata_next = {24'h000000, iev_reg[rp]};
               OFF_IM: hrdata_next = {24'h000000, im_reg[rp]};
               OFF_RIS: hrdata_next = {24'h000000, ris[rp]};
               OFF_MIS: begin
                  rbyte = ris[rp] & im_reg[rp];
                  hrdata_next = {24'h000000, rbyte};
               end
               OFF_AFSEL: hrdata_next = {24'h000000, afsel_reg[rp]};
               OFF_PUR: hrdata_next = {24'h000000, pur_reg[rp]};
               OFF_PDR: hrdata_next = {24'h000000, pdr_reg[rp]};
               OFF_DEN: hrdata_next = {24'h000000, den_reg[rp]};
               OFF_PCTL: hrdata_next = pctl_reg[rp];
               default: hrdata_next = 32'h00000000;
            endcase
         end
      end else if (accept) begin
         // Ports above E answer with zero data.
         hrdata_next = 32'h00000000;
      end

      // Write data phase: every pin field is its own bit, except the four-bit code fields of PCTL.
      if (wr_pend_reg && wp < PORT_LIMIT) begin // RULE5
         if (is_data(wr_addr_reg)) begin
            data_next[wp] = (data_next[wp] & ~wmask) |
               (hwdata[7:0] & wmask); // RULE16
         end else begin
            unique case (wr_addr_reg[11:0])
               OFF_DIR: dir_next[wp] = hwdata[7:0]; // RULE11
               OFF_IS: is_next[wp] = hwdata[7:0];
               OFF_IBE: ibe_next[wp] = hwdata[7:0];
               OFF_IEV: iev_next[wp] = hwdata[7:0];
               OFF_IM: im_next[wp] = hwdata[7:0];
               // Ones clear edge flags; zeros leave them alone.
               OFF_ICR: icr_pulse[wp] = hwdata[7:0];
               OFF_AFSEL: afsel_next[wp] = hwdata[7:0];
               OFF_PUR: pur_next[wp] = hwdata[7:0];
               OFF_PDR: pdr_next[wp] = hwdata[7:0];
               OFF_DEN: den_next[wp] = hwdata[7:0];
               // The function code register takes all 32 bits.
               OFF_PCTL: pctl_next[wp] = hwdata;
               default: begin
               end
            endcase
         end
      end
   end

   // Pin muxing and peripheral hand-off.
   always_comb begin
      for (int p = 0; p < N_PORTS; p++) begin
         // A selected pin belongs to its peripheral, otherwise the
         // data and direction registers drive it.
         pin_out_next[p] = (afsel_reg[p] & periph_out[p]) |
            (~afsel_reg[p] & data_reg[p]); // RULE18
         pin_oe_next[p] = den_reg[p] & ((afsel_reg[p] & periph_oe[p]) |
            (~afsel_reg[p] & dir_reg[p])); // RULE15
         periph_in_next[p] = pin_sync_val[p] & afsel_reg[p] &
            den_reg[p]; // RULE4
         for (int i = 0; i < N_PINS; i++) begin
            code_next[p][i*CODE_W +: CODE_W] =
               (afsel_reg[p][i] && den_reg[p][i]) ?
               pctl_reg[p][i*CODE_W +: CODE_W] : 4'h0; // RULE4
         end
         // The port line is the OR of every unmasked pending flag.
         irq_next[p] = |(ris[p] & im_reg[p]); // RULE17
      end
      adc_next = ris[ADC_PORT][ADC_PIN] & im_reg[ADC_PORT][ADC_PIN]; // RULE14
   end

   // The external reset pin is merged into hresetn upstream, so both
   // sources land here and restore the same defaults.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin // RULE8
         data_reg <= '0;
         dir_reg <= DIR_RST; // RULE9
         is_reg <= '0;
         ibe_reg <= '0;
         iev_reg <= '0;
         im_reg <= '0;
         // Port B pin 7, the serial pins and the debug pins come back as peripherals.
         afsel_reg <= AFSEL_RST; // RULE10
         pur_reg <= PUR_RST; // RULE7
         pdr_reg <= PDR_RST; // RULE6
         den_reg <= DEN_RST; // RULE7
         pctl_reg <= PCTL_RST; // RULE6
      end else begin // RULE19
         data_reg <= data_next;
         dir_reg <= dir_next;
         is_reg <= is_next;
         ibe_reg <= ibe_next;
         iev_reg <= iev_next;
         im_reg <= im_next;
         afsel_reg <= afsel_next;
         pur_reg <= pur_next;
         pdr_reg <= pdr_next;
         den_reg <= den_next;
         pctl_reg <= pctl_next;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= '0;
         hrdata_reg <= 32'h00000000;
         hready_reg <= 1'b1;
         hresp_reg <= 1'b0;
      end else begin
         wr_pend_reg <= wr_pend_next;
         wr_addr_reg <= wr_addr_next;
         hrdata_reg <= hrdata_next;
         hready_reg <= hready_next;
         hresp_reg <= hresp_next;
      end
   end

   // Registering the pins costs one cycle but keeps a back-to-back
   // write stream able to toggle a pin every second clock.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pin_out_reg <= '0;
         pin_oe_reg <= '0;
         periph_in_reg <= '0;
         code_reg <= '0;
         irq_reg <= '0;
         adc_reg <= 1'b0;
      end else begin
         pin_out_reg <= pin_out_next; // RULE2
         pin_oe_reg <= pin_oe_next;
         periph_in_reg <= periph_in_next;
         code_reg <= code_next;
         irq_reg <= irq_next;
         adc_reg <= adc_next;
      end
   end

   assign hrdata = hrdata_reg;
   assign hreadyout = hready_reg;
   assign hresp = hresp_reg;
   assign pin_out = pin_out_reg;
   assign pin_oe = pin_oe_reg;
   assign pin_pull_up = pur_reg;
   assign pin_pull_down = pdr_reg;
   assign pin_digital_en = den_reg;
   assign periph_in = periph_in_reg;
   assign pin_function_code = code_reg;
   assign port_irq = irq_reg;
   assign adc_trigger = adc_reg;
endmodule

/* File: gpio_ports_monitor.sv */
`timescale 1ns/100ps
module gpio_ports_monitor (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic hreadyout,
   input wire gpio_pkg::port_bits_t pin_oe,
   input wire gpio_pkg::port_bits_t pin_pull_up,
   input wire gpio_pkg::port_bits_t pin_digital_en,
   input wire gpio_pkg::port_bits_t periph_in,
   input wire gpio_pkg::port_codes_t pin_function_code,
   input wire logic [gpio_pkg::N_PORTS-1:0] port_irq,
   input wire logic adc_trigger
);
   import gpio_pkg::*;
   logic taken;
   assign taken = hsel && hready && htrans[1];
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   sequence one_wait;
      !hreadyout ##1 hreadyout;
   endsequence
   chk_write_one_wait: assert property (
      taken && hwrite |=> one_wait) else $error("write wait state wrong");
   chk_read_no_wait: assert property (
      taken && !hwrite |=> hreadyout) else $error("read was stalled");
   chk_adc_with_irq: assert property (
      adc_trigger |-> port_irq[ADC_PORT]) else $error("trigger unmasked");
   chk_code_after_reset: assert property (
      $rose(hresetn) |=> pin_function_code == PCTL_RST)
      else $error("function codes not at defaults");
   chk_cfg_at_reset: assert property (
      $rose(hresetn) |-> pin_digital_en == DEN_RST &&
      pin_pull_up == PUR_RST) else $error("pad config not at defaults");
   chk_irq_quiet_reset: assert property (
      $rose(hresetn) |-> (port_irq == '0 && !adc_trigger) [*3])
      else $error("interrupt right after reset");
   for (genvar i = 0; i < N_PORTS*N_PINS; i++) begin : g_pin
      logic off;
      assign off = !pin_digital_en[i/N_PINS][i%N_PINS];
      chk_code_gated: assert property (
         off && $past(off) |->
         pin_function_code[i/N_PINS][(i%N_PINS)*4 +: 4] == 4'h0)
         else $error("code shown on disabled pin");
      chk_periph_gated: assert property (
         off && $past(off) |-> !periph_in[i/N_PINS][i%N_PINS])
         else $error("disabled pin reached peripheral");
      chk_oe_gated: assert property (
         off && $past(off) |-> !pin_oe[i/N_PINS][i%N_PINS])
         else $error("disabled pin driven");
   end
endmodule

bind gpio_ports gpio_ports_monitor i_gpio_ports_monitor (.hclk(hclk),
   .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
   .hready(hready), .hreadyout(hreadyout), .pin_oe(pin_oe),
   .pin_pull_up(pin_pull_up), .pin_digital_en(pin_digital_en),
   .periph_in(periph_in), .pin_function_code(pin_function_code),
   .port_irq(port_irq), .adc_trigger(adc_trigger));

/* File: gpio_pads.sv */
`timescale 1ns/100ps
module gpio_pads (
   input wire logic hclk,
   input wire gpio_pkg::port_bits_t pin_out,
   input wire gpio_pkg::port_bits_t pin_oe,
   input wire gpio_pkg::port_bits_t pin_pull_up,
   input wire gpio_pkg::port_bits_t pin_pull_down,
   input wire gpio_pkg::port_bits_t ext_en,
   input wire gpio_pkg::port_bits_t ext_val,
   output gpio_pkg::port_bits_t pin_in
);
   import gpio_pkg::*;
   // A floating pad with no pull reads a pattern that flips every cycle,
   // so logic that samples an undriven pin cannot pass by luck.
   port_bits_t float_reg = '0;
   always_ff @(posedge hclk) begin
      float_reg <= ~float_reg;
   end
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val) |
      (~pin_oe & ~ext_en & (pin_pull_up | (~pin_pull_down & float_reg)));
endmodule

/* File: gpio_port_pin_config_test.sv */
`timescale 1ns/100ps
module gpio_port_pin_config_test;
   import gpio_pkg::*;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic [14:0] haddr = '0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = '0;
   logic [31:0] hrdata, rd;
   logic hreadyout;
   logic hresp;
   port_bits_t pin_in, pin_out, pin_oe, pin_pull_up, pin_pull_down;
   port_bits_t pin_digital_en, periph_in;
   port_bits_t periph_out = '0;
   port_bits_t periph_oe = '0;
   port_bits_t ext_en = '0;
   port_bits_t ext_val = '0;
   port_codes_t pin_function_code;
   logic [N_PORTS-1:0] port_irq;
   logic adc_trigger;
   logic [4:0] mode [5] = '{5'h05, 5'h02, 5'h09, 5'h15, 5'h12};
   int err_count = 0;
   int num_checks = 0;

   always #50 hclk = ~hclk;

   gpio_ports i_gpio_ports (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(SIZE_WORD),
      .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .pin_in(pin_in),
      .pin_out(pin_out), .pin_oe(pin_oe), .pin_pull_up(pin_pull_up),
      .pin_pull_down(pin_pull_down), .pin_digital_en(pin_digital_en),
      .periph_out(periph_out), .periph_oe(periph_oe),
      .periph_in(periph_in), .pin_function_code(pin_function_code),
      .port_irq(port_irq), .adc_trigger(adc_trigger));

   gpio_pads i_gpio_pads (.hclk(hclk), .pin_out(pin_out), .pin_oe(pin_oe),
      .pin_pull_up(pin_pull_up), .pin_pull_down(pin_pull_down),
      .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in));

   task automatic check(input string name, input logic [31:0] exp,
         input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic bus(input logic wr_en, input logic [2:0] port,
         input logic [11:0] off, input logic [31:0] wd);
      haddr <= {port, off};
      htrans <= 2'h2;
      hwrite <= wr_en;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask

   task automatic wr(input logic [2:0] port, input logic [11:0] off,
         input logic [31:0] wd);
      bus(1'b1, port, off, wd);
   endtask

   task automatic rd_chk(input string name, input logic [2:0] port,
         input logic [11:0] off, input logic [31:0] exp);
      bus(1'b0, port, off, 32'h0);
      check(name, exp, rd);
   endtask

   task automatic do_reset();
      hresetn <= 1'b0;
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
   endtask

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // The tests need a few hundred cycles; twenty thousand means a hang.
   initial begin
      #2000000;
      err_count++;
      give_verdict();
   end

   initial begin
      do_reset();
      check("oe at reset", 32'h0, {31'h0, |pin_oe});
      for (int p = 0; p < N_PORTS; p++) begin
         rd_chk("select", p[2:0], OFF_AFSEL, {24'h0, AFSEL_RST[p]});
         rd_chk("enable", p[2:0], OFF_DEN, {24'h0, DEN_RST[p]});
         rd_chk("pull up", p[2:0], OFF_PUR, {24'h0, PUR_RST[p]});
         rd_chk("pull dn", p[2:0], OFF_PDR, {24'h0, PDR_RST[p]});
         rd_chk("dir", p[2:0], OFF_DIR, {24'h0, DIR_RST[p]});
         rd_chk("code", p[2:0], OFF_PCTL, PCTL_RST[p]);
      end
      check("resp", 32'h0, {31'h0, hresp});
      check("pu out", {24'h0, PUR_RST[2]}, {24'h0, pin_pull_up[2]});
      check("pd out", 32'h0, {24'h0, pin_pull_down[2]});
      wr(3'h2, OFF_PDR, 32'hF0);
      check("pd write", 32'hF0, {24'h0, pin_pull_down[2]});
      wr(3'h3, OFF_DEN, 32'hFF);
      wr(3'h3, OFF_DIR, 32'hFF);
      wr(3'h3, 12'h3FC, 32'h00);
      wr(3'h3, 12'h098, 32'hEB);
      rd_chk("data", 3'h3, 12'h3FC, 32'h22);
      rd_chk("masked read", 3'h3, 12'h0C4, 32'h20);
      check("pin drive", 32'h22, {24'h0, pin_out[3]});
      for (int i = 0; i < 4; i++) begin
         wr(3'h3, 12'h004, i[31:0] & 32'h1);
         #1;
         check("toggle", i[31:0] & 32'h1, {31'h0, pin_out[3][0]});
      end
      wr(3'h3, OFF_DIR, 32'h00);
      ext_en[3] <= 8'hFF;
      ext_val[3] <= 8'h5A;
      repeat (8) @(posedge hclk);
      rd_chk("capture", 3'h3, 12'h3FC, 32'h5A);
      wr(3'h3, OFF_DEN, 32'h0F);
      repeat (8) @(posedge hclk);
      rd_chk("analog pin", 3'h3, 12'h3FC, 32'h0A);
      check("den out", 32'h0F, {24'h0, pin_digital_en[3]});
      wr(3'h4, OFF_DEN, 32'hFF);
      wr(3'h4, OFF_PCTL, 32'h55);
      periph_out[4] <= 8'hFF;
      periph_oe[4] <= 8'h03;
      wr(3'h4, OFF_AFSEL, 32'h01);
      repeat (8) @(posedge hclk);
      #1;
      check("alt oe", 32'h01, {24'h0, pin_oe[4]});
      check("alt code", 32'h5, pin_function_code[4]);
      check("periph in", 32'h01, {24'h0, periph_in[4]});
      wr(3'h1, OFF_DEN, 32'hFF);
      wr(3'h1, OFF_AFSEL, 32'h00);
      ext_en[1] <= 8'h10;
      for (int m = 0; m < 5; m++) begin
         wr(3'h1, OFF_IM, 32'h0);
         wr(3'h1, OFF_IS, {27'h0, mode[m][4], 4'h0});
         wr(3'h1, OFF_IBE, {27'h0, mode[m][3], 4'h0});
         wr(3'h1, OFF_IEV, {27'h0, mode[m][2], 4'h0});
         ext_val[1][4] <= mode[m][1];
         repeat (8) @(posedge hclk);
         wr(3'h1, OFF_ICR, 32'hFF);
         wr(3'h1, OFF_IM, 32'h10);
         ext_val[1][4] <= mode[m][0];
         repeat (8) @(posedge hclk);
         #1;
         check("irq", 32'h1, {31'h0, port_irq[1]});
         check("adc", 32'h1, {31'h0, adc_trigger});
         rd_chk("raw", 3'h1, OFF_RIS, 32'h10);
         rd_chk("masked", 3'h1, OFF_MIS, 32'h10);
      end
      wr(3'h1, OFF_IM, 32'h0);
      repeat (3) @(posedge hclk);
      #1;
      check("masked irq", 32'h0, {31'h0, port_irq[1]});
      rd_chk("mis off", 3'h1, OFF_MIS, 32'h0);
      rd_chk("no port", 3'h5, OFF_DIR, 32'h0);
      wr(3'h0, 12'h434, 32'hFF);
      rd_chk("unmapped", 3'h0, 12'h434, 32'h0);
      do_reset();
      rd_chk("top pin", 3'h1, OFF_AFSEL, 32'h80);
      rd_chk("dir again", 3'h3, OFF_DIR, 32'h0);
      rd_chk("enable again", 3'h4, OFF_DEN, 32'h0);
      give_verdict();
   end
endmodule
